// file: acrp_regs.svh
// constants of the configuration and readback port: fields, resets, timing
`ifndef ACRP_REGS_SVH
`define ACRP_REGS_SVH

// ****************************************************************
// word widths
// ****************************************************************
`define ACRP_CFG_W        16
`define ACRP_RES_W        12
`define ACRP_FRAME_W      28
`define ACRP_FRAME_MSB    5'h1b
`define ACRP_FRAME_BITS   5'h1c
`define ACRP_RES_BITS     5'h0c
`define ACRP_CFG_BITS     5'h10
`define ACRP_CFG_LAST     5'h0f

// ****************************************************************
// configuration word fields
// ****************************************************************
`define ACRP_KEY_HI       15
`define ACRP_KEY_LO       14
`define ACRP_CH_HI        13
`define ACRP_CH_LO        11
`define ACRP_PM_HI        10
`define ACRP_PM_LO        9
`define ACRP_READBACK_ENABLE_BIT     7
`define ACRP_KEY_LOAD     2'h3
`define ACRP_PM_PDOWN     2'h0
`define ACRP_PM_CONT      2'h1

// ****************************************************************
// reset values
// ****************************************************************
`define ACRP_CFG_RST      16'h0200
`define ACRP_FRAME_RST    28'h0000000

// ****************************************************************
// timing
// ****************************************************************
`define ACRP_CLK_PS       4000
`define ACRP_CONV_NS      3600
`define ACRP_CONV_W       10
`define ACRP_CONV_CYC     ((`ACRP_CONV_NS * 1000 + `ACRP_CLK_PS - 1) / `ACRP_CLK_PS)
`define ACRP_WAKE_PD_US   150
`define ACRP_WAKE_PD_CYC  ((`ACRP_WAKE_PD_US * 1000000 + `ACRP_CLK_PS - 1) / `ACRP_CLK_PS)
`define ACRP_WAKE_SLP_CYC 16
`define ACRP_WAKE_W       20

`endif

// file: acrp_pkg.sv
// types of the configuration and readback port
package acrp_pkg;

   // ****************************************************************
   // converter sequence and power states
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACQ,
      ST_CONV
   } acrp_state_t;

   typedef enum logic [1:0] {
      PWR_FULL,
      PWR_DOWN,
      PWR_SLEEP,
      PWR_WAKE
   } acrp_pwr_t;

endpackage

// file: acrp_serial.sv
// serial-clock side: readback shifter and configuration word receiver
`include "acrp_regs.svh"

module acrp_serial (
   input  wire logic                      sclk_i,
   input  wire logic                      clr_i,
   input  wire logic                      rst_i,
   input  wire logic                      sdi_i,
   input  wire logic [`ACRP_FRAME_W-1:0]  word_i,
   input  wire logic                      rb_en_i,
   output logic                           sdo_o,
   output logic      [`ACRP_CFG_W-1:0]    cfg_o,
   output logic                           cfg_tgl_o
);
   import acrp_pkg::*;

   logic [4:0]              out_cnt;
   logic [4:0]              in_cnt;
   logic [`ACRP_CFG_W-2:0]  in_sh;

   // ****************************************************************
   // output shifter, falling edges
   // ****************************************************************
   wire [4:0] out_lim  = rb_en_i ? `ACRP_FRAME_BITS : `ACRP_RES_BITS;
   wire       out_more = out_cnt < out_lim;
   wire [4:0] out_idx  = `ACRP_FRAME_MSB - out_cnt;

   // result first, then the configuration word while readback is on
   always_ff @(negedge sclk_i or posedge clr_i) begin
      if (clr_i) begin
         out_cnt <= 5'h00;
         sdo_o   <= 1'b1;
      end else if (out_more) begin
         sdo_o   <= word_i[out_idx];
         out_cnt <= out_cnt + 5'h01;
      end else begin
         sdo_o   <= 1'b0;
      end
   end

   // ****************************************************************
   // input shifter, rising edges, msb first
   // ****************************************************************
   wire in_more = in_cnt < `ACRP_CFG_BITS;
   wire in_last = in_cnt == `ACRP_CFG_LAST;

   always_ff @(posedge sclk_i or posedge clr_i) begin
      if (clr_i) begin
         in_cnt <= 5'h00;
         in_sh  <= '0;
      end else if (in_more) begin
         in_sh  <= {in_sh[`ACRP_CFG_W-3:0], sdi_i};
         in_cnt <= in_cnt + 5'h01;
      end
   end

   // the full word is held and announced by a toggle
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_o     <= '0;
         cfg_tgl_o <= 1'b0;
      end else if (in_last) begin
         cfg_o     <= {in_sh, sdi_i};
         cfg_tgl_o <= ~cfg_tgl_o;
      end
   end

endmodule

// file: acrp_top.sv
// converter sequencer, configuration store and readback word holder
`include "acrp_regs.svh"

module acrp_top #(
   parameter int unsigned WAKE_PD_CYC  = `ACRP_WAKE_PD_CYC,
   parameter int unsigned WAKE_SLP_CYC = `ACRP_WAKE_SLP_CYC
) (
   input  wire logic                    clk_i,
   input  wire logic                    srst_i,
   input  wire logic                    conversion_strobe_i,
   input  wire logic                    sclk_i,
   input  wire logic                    sdi_i,
   input  wire logic [`ACRP_RES_W-1:0]  result_i,
   output logic                         sdo_o,
   output logic                         sdo_oe_o,
   output logic                         conv_start_o,
   output logic                         converting_o,
   output logic                         acquiring_o,
   output logic      [2:0]              channel_select_o,
   output acrp_pkg::acrp_pwr_t          power_state_o,
   output logic                         ready_o,
   output logic      [`ACRP_CFG_W-1:0]  config_word_o
);
   import acrp_pkg::*;

   localparam logic [`ACRP_CONV_W-1:0] CONV_LOAD =
      `ACRP_CONV_W'(`ACRP_CONV_CYC - 1);
   localparam logic [`ACRP_WAKE_W-1:0] WAKE_PD_LOAD =
      `ACRP_WAKE_W'(WAKE_PD_CYC - 1);
   localparam logic [`ACRP_WAKE_W-1:0] WAKE_SLP_LOAD =
      `ACRP_WAKE_W'(WAKE_SLP_CYC - 1);

   // ****************************************************************
   // helpers
   // ****************************************************************
   // keeps the used fields only; key and unused bits read as zero
   function automatic logic [`ACRP_CFG_W-1:0] cfg_clean(
      input logic [`ACRP_CFG_W-1:0] w
   );
      logic [`ACRP_CFG_W-1:0] c;
      c = '0;
      c[`ACRP_CH_HI:`ACRP_CH_LO] = w[`ACRP_CH_HI:`ACRP_CH_LO];
      c[`ACRP_PM_HI:`ACRP_PM_LO] = w[`ACRP_PM_HI:`ACRP_PM_LO];
      c[`ACRP_READBACK_ENABLE_BIT]          = w[`ACRP_READBACK_ENABLE_BIT];
      return c;
   endfunction

   // power state entered when a conversion under this word ends
   function automatic acrp_pwr_t pwr_after(
      input logic [`ACRP_CFG_W-1:0] w
   );
      logic [1:0] pm;
      pm = w[`ACRP_PM_HI:`ACRP_PM_LO];
      if (pm[1])
         return PWR_SLEEP;
      else if (pm == `ACRP_PM_PDOWN)
         return PWR_DOWN;
      else
         return PWR_FULL;
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic                     cnv_s1;
   logic                     cnv_s2;
   logic                     cnv_s3;
   logic                     tgl_s1;
   logic                     tgl_s2;
   logic                     tgl_s3;
   logic                     rd_clr;
   logic                     rst_q;
   acrp_state_t              state;
   acrp_state_t              next_state;
   acrp_pwr_t                pwr;
   acrp_pwr_t                next_pwr;
   logic [`ACRP_CONV_W-1:0]  conv_cnt;
   logic [`ACRP_WAKE_W-1:0]  wake_cnt;
   logic [`ACRP_CFG_W-1:0]   pend_cfg;
   logic [`ACRP_CFG_W-1:0]   act_cfg;
   logic [`ACRP_FRAME_W-1:0] out_word;
   logic [`ACRP_CFG_W-1:0]   rx_cfg;
   logic                     rx_tgl;

   // ****************************************************************
   // strobe and toggle synchronisers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnv_s1 <= 1'b1;
         cnv_s2 <= 1'b1;
         cnv_s3 <= 1'b1;
      end else begin
         cnv_s1 <= conversion_strobe_i;
         cnv_s2 <= cnv_s1;
         cnv_s3 <= cnv_s2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
      end else begin
         tgl_s1 <= rx_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
      end
   end

   wire cnv_fall = ~cnv_s2 & cnv_s3;
   wire cnv_rise = cnv_s2 & ~cnv_s3;
   wire cfg_new  = tgl_s2 ^ tgl_s3;

   // ****************************************************************
   // sequence: idle, acquisition, conversion
   // ****************************************************************
   wire conv_done = (state == ST_CONV) && (conv_cnt == '0);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cnv_fall)
               next_state = ST_ACQ;
         end
         ST_ACQ: begin
            if (cnv_rise)
               next_state = ST_CONV;
         end
         ST_CONV: begin
            if (conv_done)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   wire conv_go = (state == ST_ACQ) && cnv_rise;

   always_ff @(posedge clk_i) begin
      if (srst_i)
         conv_cnt <= '0;
      else if (conv_go)
         conv_cnt <= CONV_LOAD;
      else if (state == ST_CONV && conv_cnt != '0)
         conv_cnt <= conv_cnt - `ACRP_CONV_W'(1);
   end

   // ****************************************************************
   // power policy
   // ****************************************************************
   wire wake_go = (state == ST_IDLE) && cnv_fall;

   always_comb begin
      next_pwr = pwr;
      case (pwr)
         PWR_FULL: begin
            if (conv_done)
               next_pwr = pwr_after(act_cfg);
         end
         PWR_DOWN, PWR_SLEEP: begin
            if (wake_go)
               next_pwr = PWR_WAKE;
         end
         PWR_WAKE: begin
            if (wake_cnt == '0)
               next_pwr = PWR_FULL;
         end
         default: next_pwr = PWR_FULL;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i)
         pwr <= PWR_FULL;
      else
         pwr <= next_pwr;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i)
         wake_cnt <= '0;
      else if (wake_go && pwr == PWR_DOWN)
         wake_cnt <= WAKE_PD_LOAD;
      else if (wake_go && pwr == PWR_SLEEP)
         wake_cnt <= WAKE_SLP_LOAD;
      else if (wake_cnt != '0)
         wake_cnt <= wake_cnt - `ACRP_WAKE_W'(1);
   end

   // ****************************************************************
   // configuration store
   // ****************************************************************
   wire key_ok = rx_cfg[`ACRP_KEY_HI:`ACRP_KEY_LO] == `ACRP_KEY_LOAD;

   // pending settings wait for the end of the running conversion
   always_ff @(posedge clk_i) begin
      if (srst_i)
         pend_cfg <= `ACRP_CFG_RST;
      else if (cfg_new && key_ok)
         pend_cfg <= cfg_clean(rx_cfg);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i)
         act_cfg <= `ACRP_CFG_RST;
      else if (conv_done)
         act_cfg <= pend_cfg;
   end

   // result and the settings it was taken under, read out next time
   always_ff @(posedge clk_i) begin
      if (srst_i)
         out_word <= `ACRP_FRAME_RST;
      else if (conv_done)
         out_word <= {result_i, act_cfg};
   end

   // restarts both shifters whenever a new word is on offer
   always_ff @(posedge clk_i) begin
      rd_clr <= srst_i | conv_done;
      rst_q  <= srst_i;
   end

   // ****************************************************************
   // serial-clock domain
   // ****************************************************************
   acrp_serial u_serial (
      .sclk_i    (sclk_i),
      .clr_i     (rd_clr),
      .rst_i     (rst_q),
      .sdi_i     (sdi_i),
      .word_i    (out_word),
      .rb_en_i   (out_word[`ACRP_READBACK_ENABLE_BIT]),
      .sdo_o     (sdo_o),
      .cfg_o     (rx_cfg),
      .cfg_tgl_o (rx_tgl)
   );

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sdo_oe_o     <= 1'b0;
         conv_start_o <= 1'b0;
         converting_o <= 1'b0;
         acquiring_o  <= 1'b0;
      end else begin
         sdo_oe_o     <= ~cnv_s2;
         conv_start_o <= conv_go;
         converting_o <= next_state == ST_CONV;
         acquiring_o  <= next_state == ST_ACQ;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         channel_select_o <= 3'h0;
         power_state_o    <= PWR_FULL;
         ready_o          <= 1'b1;
         config_word_o    <= `ACRP_CFG_RST;
      end else begin
         channel_select_o <= act_cfg[`ACRP_CH_HI:`ACRP_CH_LO];
         power_state_o    <= next_pwr;
         ready_o          <= next_pwr == PWR_FULL;
         config_word_o    <= act_cfg;
      end
   end

endmodule

// file: acrp_asserts.sv
// checker of sequencing, output enable, configuration and power outputs
`include "acrp_regs.svh"

module acrp_chk (
   input  wire logic                    clk_i,
   input  wire logic                    srst_i,
   input  wire logic                    conversion_strobe_i,
   input  wire logic                    sdo_oe_o,
   input  wire logic                    conv_start_o,
   input  wire logic                    converting_o,
   input  wire logic                    acquiring_o,
   input  wire logic [2:0]              channel_select_o,
   input  wire acrp_pkg::acrp_pwr_t     power_state_o,
   input  wire logic                    ready_o,
   input  wire logic [`ACRP_CFG_W-1:0]  config_word_o
);
   import acrp_pkg::*;
   logic [9:0] conv_cnt;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   // length of the running conversion in clk cycles
   always_ff @(posedge clk_i) begin
      if (srst_i || !converting_o) begin
         conv_cnt <= 10'h000;
      end else begin
         conv_cnt <= conv_cnt + 10'h001;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_oe_strobe_high: assert property (
      conversion_strobe_i [*4] |-> !sdo_oe_o)
      else $error("serial output driven while strobe high");
   a_oe_strobe_low: assert property (
      !conversion_strobe_i [*5] |-> sdo_oe_o)
      else $error("serial output floating while strobe low");
   a_start_one_cycle: assert property (
      conv_start_o |-> converting_o && !acquiring_o ##1 !conv_start_o)
      else $error("conversion start pulse malformed");
   a_acq_after_fall: assert property (
      $fell(conversion_strobe_i) && !converting_o && !acquiring_o
      |-> ##[2:6] acquiring_o)
      else $error("no acquisition after strobe fall");
   a_conv_length: assert property (
      $fell(converting_o) |-> conv_cnt inside {[10'h383:10'h385]})
      else $error("conversion length wrong");
   a_cfg_at_end: assert property (
      $changed(config_word_o) |-> !converting_o
      && ($past(converting_o) || $past(converting_o, 2)))
      else $error("configuration changed away from conversion end");
   a_chan_from_cfg: assert property (
      channel_select_o == config_word_o[`ACRP_CH_HI:`ACRP_CH_LO])
      else $error("channel differs from configuration");
   a_unused_zero: assert property (
      config_word_o[15:14] == 2'h0 && !config_word_o[8]
      && config_word_o[6:0] == 7'h00)
      else $error("unused configuration bits set");
   a_ready_full: assert property (
      ready_o == (power_state_o == PWR_FULL))
      else $error("ready disagrees with power state");
   a_low_power_end: assert property (
      $changed(power_state_o)
      && (power_state_o inside {PWR_DOWN, PWR_SLEEP})
      |-> !converting_o && ($past(converting_o) || $past(converting_o, 2)))
      else $error("low power entered away from conversion end");

   c_conv: cover property (conv_start_o);
   c_down: cover property (power_state_o == PWR_DOWN);
   c_sleep: cover property (power_state_o == PWR_SLEEP);
endmodule

bind acrp_top acrp_chk chk (
   .clk_i               (clk_i),
   .srst_i              (srst_i),
   .conversion_strobe_i (conversion_strobe_i),
   .sdo_oe_o            (sdo_oe_o),
   .conv_start_o        (conv_start_o),
   .converting_o        (converting_o),
   .acquiring_o         (acquiring_o),
   .channel_select_o    (channel_select_o),
   .power_state_o       (power_state_o),
   .ready_o             (ready_o),
   .config_word_o       (config_word_o)
);

// file: acrp_host.sv
// host model: conversion strobe, serial clock and serial data
module acrp_host (
   input  wire logic clk_i,
   input  wire logic sdo_i,
   output logic      strobe_o,
   output logic      sclk_o,
   output logic      sdi_o
);
   initial begin
      strobe_o = 1'b1;
      sclk_o   = 1'b0;
      sdi_o    = 1'b0;
   end

   // acquisition with one 29-bit exchange; sdi toggles once the word is in
   task automatic exchange(input logic [15:0] w, output logic [28:0] got);
      @(posedge clk_i);
      #1 strobe_o = 1'b0;
      #43;
      for (int i = 0; i < 29; i++) begin
         sdi_o = (i < 16) ? w[15 - i] : ~sdi_o;
         #12 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
         #12 got[28 - i] = sdo_i;
      end
   endtask

   // frame done and wake-up past before the rise; clock parked low
   task automatic convert();
      @(posedge clk_i);
      #1 strobe_o = 1'b1;
      #4000;
   endtask
endmodule

// file: tb_top.sv
// testbench: loads, readback frames and power policies of the port
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import acrp_pkg::*;

   logic        clk_i    = 1'b0;
   logic        srst_i   = 1'b1;
   logic [11:0] result_i = 12'h000;
   logic        strobe;
   logic        sclk;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        ready;
   logic [2:0]  chan;
   logic [15:0] cfg_w;
   acrp_pwr_t   pwr;
   wire         sdo_line;
   int          fail_count  = 0;
   int          comparisons = 0;

   always #2 clk_i = ~clk_i;
   // released line shows a changing pattern
   assign sdo_line = sdo_oe ? sdo : clk_i;

   acrp_top #(
      .WAKE_PD_CYC  (20),
      .WAKE_SLP_CYC (4)
   ) dut (
      .clk_i               (clk_i),
      .srst_i              (srst_i),
      .conversion_strobe_i (strobe),
      .sclk_i              (sclk),
      .sdi_i               (sdi),
      .result_i            (result_i),
      .sdo_o               (sdo),
      .sdo_oe_o            (sdo_oe),
      .conv_start_o        (),
      .converting_o        (),
      .acquiring_o         (),
      .channel_select_o    (chan),
      .power_state_o       (pwr),
      .ready_o             (ready),
      .config_word_o       (cfg_w)
   );

   acrp_host host (
      .clk_i    (clk_i),
      .sdo_i    (sdo_line),
      .strobe_o (strobe),
      .sclk_o   (sclk),
      .sdi_o    (sdi)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one acquisition and conversion; frame is the previous readback
   task automatic step(input logic [15:0] w, input logic [11:0] res,
         input logic [27:0] frame, input logic [15:0] cfg, input acrp_pwr_t p);
      logic [28:0] got;
      @(posedge clk_i);
      #1 result_i = res;
      host.exchange(w, got);
      check({2'h0, sdo_oe, got}, {3'h1, frame, 1'b0});
      host.convert();
      check({16'h0, cfg_w}, {16'h0, cfg});
      check({28'h0, sdo_oe, chan}, {29'h0, cfg[13:11]});
      check({29'h0, ready, pwr}, {29'h0, p == PWR_FULL, p});
   endtask

   task automatic t_defaults();
      check({12'h0, sdo_oe, ready, pwr, cfg_w}, {14'h1, PWR_FULL, 16'h0200});
   endtask

   task automatic t_load();
      step(16'hebff, 12'h801, 28'h0000000, 16'h2a80, PWR_FULL);
      step(16'h9e80, 12'h7fe, 28'h8010000, 16'h2a80, PWR_FULL);
   endtask

   task automatic t_readback();
      step(16'hd080, 12'h5a3, 28'h7fe2a80, 16'h1080, PWR_FULL);
      step(16'hfe00, 12'hc3c, 28'h5a32a80, 16'h3e00, PWR_DOWN);
   endtask

   task automatic t_power();
      step(16'h0000, 12'h0ff, 28'hc3c1080, 16'h3e00, PWR_SLEEP);
      step(16'hc200, 12'h456, 28'h0ff0000, 16'h0200, PWR_SLEEP);
      step(16'h0000, 12'h000, 28'h4560000, 16'h0200, PWR_FULL);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      #1 srst_i = 1'b0;
      t_defaults();
      t_load();
      t_readback();
      t_power();
      close_out();
   end

   initial begin
      #100000;
      fail_count++;
      close_out();
   end
endmodule
